// >>> logic/ccp_pkg.sv
// Purpose: shared constants and types for the core clock / nmi front end
// Assumes: one clock domain, registers reached over a plain strobe port
// Notes:   offsets are byte addresses, registers are 32-bit words
`default_nettype none
package ccp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  OFF_PLL_CTL   = 8'h00;  // pll_control_reg
  localparam logic [7:0]  OFF_OP_MODE   = 8'h04;  // operating mode register
  localparam logic [7:0]  OFF_STATUS    = 8'h08;  // status register
  localparam logic [7:0]  OFF_PERIOD    = 8'h0C;  // measured input period

  // pll_control_reg fields
  localparam int unsigned PLL_ON_BIT    = 0;
  localparam int unsigned FACT_W        = 8;
  localparam int unsigned MUL_LSB       = 8;
  localparam int unsigned DIV_LSB       = 16;
  localparam logic [7:0]  MUL_RST       = 8'h01;
  localparam logic [7:0]  DIV_RST       = 8'h01;

  // operating mode and status fields
  localparam int unsigned ASYNC_ARB_BIT = 0;
  localparam int unsigned NMI_SEEN_BIT  = 0;
  localparam int unsigned PLL_LOCK_BIT  = 1;
  localparam int unsigned CLK_OUT_BIT   = 2;

  // period measurement
  localparam int unsigned PER_W         = 16;
  localparam int unsigned ACC_W         = PER_W + FACT_W + 1;

  // register bus request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ccp_bus_req_t;

  // bus arbitration inputs bundle (active low)
  typedef struct packed {
    logic bus_busy_n;
    logic bus_grant_n;
  } ccp_arb_t;
endpackage
`default_nettype wire

// >>> logic/ccp_edge.sv
// Purpose: registered edge detector for a synchronous level
// Assumes: input already synchronous to clk_sys
// Notes:   rise and fall are one-cycle pulses, one cycle after the change
`default_nettype none
module ccp_edge (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // level in, pulses out
  input  wire logic level_in,
  output logic      rise,
  output logic      fall
);
  logic level_reg;

  // remember last level and flag its changes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_reg <= 1'b1;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      level_reg <= level_in;
      rise      <= level_in & ~level_reg;
      fall      <= ~level_in & level_reg;
    end
  end
endmodule
`default_nettype wire

// >>> logic/ccp_core_clock.sv
// Purpose: clock front end: clock output synthesis, strap capture, nmi edge
//          capture and bus arbitration input sampling
// Assumes: ext_clock_in far slower than clk_sys, sampled as a plain input
// Notes:   synthesised clock must stay below half of clk_sys
//
// Contract
// - clock output follows internal core clock phase
// - pll on, factors one: output aligned to input
// - pll off: output is half input frequency
// - strap copied into pll on bit during reset
// - nmi falling edge after reset, synced to output clock
// - async arbitration bit frees busy/grant from clock timing
`default_nettype none
module ccp_core_clock
  import ccp_pkg::*;
#(
  parameter int unsigned PERIOD_W = ccp_pkg::PER_W
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // register port
  input  wire ccp_pkg::ccp_bus_req_t bus_req,
  output logic [ccp_pkg::DATA_W-1:0] rdata,
  // clock pins
  input  wire logic                  ext_clock_in,
  output logic                       crystal_drive_out,
  output logic                       core_clock_out,
  // strap and interrupt
  input  wire logic                  pll_init_strap,
  input  wire logic                  nmi_n,
  output logic                       nmi_request,
  // bus arbitration
  input  wire ccp_pkg::ccp_arb_t     arb_in,
  output logic                       bus_busy_seen,
  output logic                       bus_grant_seen,
  output logic                       async_arb_enable
);
  import ccp_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic              pll_on_reg;
  logic [FACT_W-1:0] mul_reg;
  logic [FACT_W-1:0] div_reg;
  logic              nmi_seen_reg;
  logic              nmi_pend_reg;
  logic              locked_reg;
  logic [PERIOD_W-1:0] per_cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [ACC_W-1:0]  acc_reg;
  logic [ACC_W-1:0]  acc_next;
  logic [ACC_W-1:0]  limit;
  logic              tick;
  logic              unity;
  logic              ext_rise;
  logic              nmi_fall;
  logic              clk_rise;
  logic [1:0]        busy_sync_reg;
  logic [1:0]        grant_sync_reg;
  logic              wr_ctl;
  logic              wr_mode;
  logic              wr_stat;

  assign wr_ctl  = bus_req.wr && (bus_req.addr == OFF_PLL_CTL);
  assign wr_mode = bus_req.wr && (bus_req.addr == OFF_OP_MODE);
  assign wr_stat = bus_req.wr && (bus_req.addr == OFF_STATUS);

  // ---------------------------------------------------------------
  // edge detection on the input clock and the interrupt pin
  // ---------------------------------------------------------------
  ccp_edge u_ext_edge (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .level_in (ext_clock_in),
    .rise     (ext_rise),
    .fall     ()
  );

  ccp_edge u_nmi_edge (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .level_in (nmi_n),
    .rise     (),
    .fall     (nmi_fall)
  );

  // oscillator drive is the inverted input, as a crystal amplifier would
  always_ff @(posedge clk_sys) begin
    if (srst) crystal_drive_out <= 1'b0;
    else      crystal_drive_out <= ~ext_clock_in;
  end

  // ---------------------------------------------------------------
  // pll control register
  // ---------------------------------------------------------------
  // strap level taken into the enable bit while reset is held
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pll_on_reg <= pll_init_strap;
      mul_reg    <= MUL_RST;
      div_reg    <= DIV_RST;
    end else if (wr_ctl) begin
      pll_on_reg <= bus_req.wdata[PLL_ON_BIT];
      mul_reg    <= (bus_req.wdata[MUL_LSB +: FACT_W] == '0) ? MUL_RST
                                                            : bus_req.wdata[MUL_LSB +: FACT_W];
      div_reg    <= (bus_req.wdata[DIV_LSB +: FACT_W] == '0) ? DIV_RST
                                                            : bus_req.wdata[DIV_LSB +: FACT_W];
    end
  end

  // operating mode: asynchronous arbitration select
  always_ff @(posedge clk_sys) begin
    if (srst)         async_arb_enable <= 1'b0;
    else if (wr_mode) async_arb_enable <= bus_req.wdata[ASYNC_ARB_BIT];
  end

  // ---------------------------------------------------------------
  // input period measurement
  // ---------------------------------------------------------------
  // counts clk_sys cycles between input rising edges, saturating
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      per_cnt_reg <= '0;
      period_reg  <= '0;
      locked_reg  <= 1'b0;
    end else if (ext_rise) begin
      per_cnt_reg <= {{(PERIOD_W-1){1'b0}}, 1'b1};
      period_reg  <= per_cnt_reg;
      locked_reg  <= (per_cnt_reg != '0) && (per_cnt_reg != '1);
    end else if (per_cnt_reg != '1) begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // core clock synthesis
  // ---------------------------------------------------------------
  // phase accumulator: adds 2*mul per cycle, wraps at period*div, so the
  // output toggles 2*mul/div times per input period
  assign limit = ACC_W'(period_reg * div_reg);
  assign unity = (mul_reg == MUL_RST) && (div_reg == DIV_RST);

  always_comb begin
    acc_next = acc_reg + ACC_W'({mul_reg, 1'b0});
    tick     = 1'b0;
    if (acc_next >= limit) begin
      acc_next = acc_next - limit;
      tick     = 1'b1;
    end
  end

  // output clock: pll off halves input, pll on runs from the accumulator
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_reg        <= '0;
      core_clock_out <= 1'b0;
    end else if (!pll_on_reg) begin
      acc_reg <= '0;
      if (ext_rise) core_clock_out <= ~core_clock_out;
    end else if (!locked_reg) begin
      acc_reg <= '0;
    end else if (unity && ext_rise) begin
      acc_reg        <= '0;
      core_clock_out <= 1'b1;
    end else begin
      acc_reg <= acc_next;
      if (tick) core_clock_out <= ~core_clock_out;
    end
  end

  // rising edge of the output clock, the core clock phase reference
  assign clk_rise = tick && pll_on_reg && locked_reg && !core_clock_out
                 && !(unity && ext_rise)
                 || (!pll_on_reg && ext_rise && !core_clock_out)
                 || (pll_on_reg && locked_reg && unity && ext_rise && !core_clock_out);

  // ---------------------------------------------------------------
  // nonmaskable interrupt
  // ---------------------------------------------------------------
  // falling edge held pending until the next output clock rising edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nmi_pend_reg <= 1'b0;
      nmi_request  <= 1'b0;
    end else begin
      nmi_request <= nmi_pend_reg && clk_rise;
      if (nmi_fall)      nmi_pend_reg <= 1'b1;
      else if (clk_rise) nmi_pend_reg <= 1'b0;
    end
  end

  // sticky status copy, a new request beats a software clear
  always_ff @(posedge clk_sys) begin
    if (srst)                                   nmi_seen_reg <= 1'b0;
    else if (nmi_pend_reg && clk_rise)          nmi_seen_reg <= 1'b1;
    else if (wr_stat && bus_req.wdata[NMI_SEEN_BIT]) nmi_seen_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // bus arbitration sampling
  // ---------------------------------------------------------------
  // two-stage synchronisers for the asynchronous mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_sync_reg  <= 2'h3;
      grant_sync_reg <= 2'h3;
    end else begin
      busy_sync_reg  <= {busy_sync_reg[0], arb_in.bus_busy_n};
      grant_sync_reg <= {grant_sync_reg[0], arb_in.bus_grant_n};
    end
  end

  // async mode takes synchronised levels any cycle, else only on clock edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_busy_seen  <= 1'b0;
      bus_grant_seen <= 1'b0;
    end else if (async_arb_enable) begin
      bus_busy_seen  <= ~busy_sync_reg[1];
      bus_grant_seen <= ~grant_sync_reg[1];
    end else if (clk_rise) begin
      bus_busy_seen  <= ~arb_in.bus_busy_n;
      bus_grant_seen <= ~arb_in.bus_grant_n;
    end
  end

  // ---------------------------------------------------------------
  // read port, data one cycle after the strobe, zero otherwise
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (bus_req.rd) begin
        if (bus_req.addr == OFF_PLL_CTL) begin
          rdata[PLL_ON_BIT]          <= pll_on_reg;
          rdata[MUL_LSB +: FACT_W]   <= mul_reg;
          rdata[DIV_LSB +: FACT_W]   <= div_reg;
        end else if (bus_req.addr == OFF_OP_MODE) begin
          rdata[ASYNC_ARB_BIT]       <= async_arb_enable;
        end else if (bus_req.addr == OFF_STATUS) begin
          rdata[NMI_SEEN_BIT]        <= nmi_seen_reg;
          rdata[PLL_LOCK_BIT]        <= locked_reg;
          rdata[CLK_OUT_BIT]         <= core_clock_out;
        end else if (bus_req.addr == OFF_PERIOD) begin
          rdata[PERIOD_W-1:0]        <= period_reg;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/ccp_properties.sv
// Purpose: port-level checks for the clock front end
// Assumes: pll settings are tracked from the strap and bus writes
// Notes:   bound to every ccp_core_clock instance
`default_nettype none
module ccp_properties
  import ccp_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire ccp_pkg::ccp_bus_req_t bus_req,
  input wire logic [ccp_pkg::DATA_W-1:0] rdata,
  input wire logic                  ext_clock_in,
  input wire logic                  core_clock_out,
  input wire logic                  pll_init_strap,
  input wire logic                  nmi_n,
  input wire logic                  nmi_request,
  input wire ccp_pkg::ccp_arb_t     arb_in,
  input wire logic                  bus_busy_seen,
  input wire logic                  bus_grant_seen,
  input wire logic                  async_arb_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic       pll_on, unity, ext_q, arb_bit;
  logic [1:0] age;
  wire logic  ctl_wr = bus_req.wr && bus_req.addr == OFF_PLL_CTL;
  wire logic  ext_up = ext_clock_in && !ext_q;
  // --------------------------------------------------------------
  // shadow of pll settings, input rises seen since they changed
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    ext_q <= ext_clock_in;
    if (srst) begin
      pll_on <= pll_init_strap;
      unity  <= 1'b1;
      age    <= 2'h0;
    end else if (ctl_wr) begin
      pll_on <= bus_req.wdata[PLL_ON_BIT];
      unity  <= bus_req.wdata[23:16] < 8'h02 && bus_req.wdata[15:8] < 8'h02;
      age    <= 2'h0;
    end else if (ext_up && age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  // last written arbitration mode bit
  always_ff @(posedge clk_sys) begin
    if (bus_req.wr && bus_req.addr == OFF_OP_MODE) begin
      arb_bit <= bus_req.wdata[ASYNC_ARB_BIT];
    end
  end

  strap_capture_a:
  assert property ($past(bus_req.rd) && $past(bus_req.addr) == OFF_PLL_CTL
    |-> rdata[PLL_ON_BIT] == pll_on) else $error("pll on bit wrong");
  half_rate_a:
  assert property (!pll_on && age != 2'h0 && ext_up |-> ##[1:3] $changed(core_clock_out))
    else $error("output missed a toggle");
  input_aligned_a:
  assert property (pll_on && unity && age == 2'h3 && ext_up |-> ##[1:3] core_clock_out)
    else $error("output not aligned to input");
  nmi_on_edge_a:
  assert property (nmi_request |-> core_clock_out && !$past(core_clock_out))
    else $error("nmi request off output edge");
  nmi_answer_a:
  assert property ($fell(nmi_n) |-> ##[2:40] nmi_request ##1 !nmi_request)
    else $error("nmi request missing");
  arb_async_a:
  assert property (async_arb_enable && $past(async_arb_enable, 3)
    |-> bus_busy_seen == !$past(arb_in.bus_busy_n, 3)) else $error("busy sync wrong");
  grant_async_a:
  assert property (async_arb_enable && $past(async_arb_enable, 3)
    |-> bus_grant_seen == !$past(arb_in.bus_grant_n, 3)) else $error("grant sync wrong");
  arb_sync_a:
  assert property (!$past(async_arb_enable) && $rose(core_clock_out)
    |-> bus_busy_seen == !$past(arb_in.bus_busy_n)
     && bus_grant_seen == !$past(arb_in.bus_grant_n)) else $error("arbitration sample wrong");
  arb_mode_a:
  assert property (ctl_wr == 1'b0 && bus_req.wr && bus_req.addr == OFF_OP_MODE ##1 !bus_req.wr
    |=> async_arb_enable == arb_bit) else $error("arbitration mode wrong");

  cover property (nmi_request);
  cover property (pll_on && unity && age == 2'h3 && ext_up);
  cover property (async_arb_enable && bus_busy_seen);
  cover property (!async_arb_enable && $rose(core_clock_out));
endmodule

bind ccp_core_clock ccp_properties chk (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
  .rdata(rdata), .ext_clock_in(ext_clock_in), .core_clock_out(core_clock_out),
  .pll_init_strap(pll_init_strap), .nmi_n(nmi_n), .nmi_request(nmi_request),
  .arb_in(arb_in), .bus_busy_seen(bus_busy_seen), .bus_grant_seen(bus_grant_seen),
  .async_arb_enable(async_arb_enable));
`default_nettype wire

// >>> tb/ccp_board.sv
// Purpose: crystal source and board logic around the clock front end
// Assumes: input clock period is 2**(HB+1) system cycles
// Notes:   arbitration lines wander with no tie to the output clock
`default_nettype none
module ccp_board
  import ccp_pkg::*;
#(
  parameter int unsigned HB = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              strap_lvl,
  output logic                   ext_clock_in,
  output logic                   pll_init_strap,
  output var ccp_pkg::ccp_arb_t  arb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  // free-running source
  always_ff @(posedge clk_sys) begin
    cnt <= cnt + 8'h01;
  end
  assign ext_clock_in   = cnt[HB];
  assign pll_init_strap = strap_lvl;
  assign arb_in         = {cnt[4] ^ cnt[1], cnt[5]};
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking run of the clock front end
// Assumes: input clock of eight system cycles per period
// Notes:   output rate is counted over sixteen input periods
`default_nettype none
module testbench
  import ccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic         strap = 1'b0;
  logic         nmi_n = 1'b1;
  ccp_bus_req_t req = '0;
  logic [31:0]  rdata, d;
  logic         ext, core, nmi_req, pin, seen, xdrv, xq;
  ccp_arb_t     arb;
  int           miscompares = 0;
  int           num_checks = 0;
  logic [31:0]  cfg [4] = '{32'h0001_0101, 32'h0001_0201, 32'h0002_0301, 32'h0000_0001};
  logic [31:0]  rate [4] = '{32'h10, 32'h20, 32'h18, 32'h10};

  always #2 clk_sys = !clk_sys;

  ccp_board board (.clk_sys(clk_sys), .strap_lvl(strap), .ext_clock_in(ext),
    .pll_init_strap(pin), .arb_in(arb));
  ccp_core_clock dut (.clk_sys(clk_sys), .srst(srst), .bus_req(req), .rdata(rdata),
    .ext_clock_in(ext), .crystal_drive_out(xdrv), .core_clock_out(core), .pll_init_strap(pin),
    .nmi_n(nmi_n), .nmi_request(nmi_req), .arb_in(arb), .bus_busy_seen(),
    .bus_grant_seen(), .async_arb_enable());

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // output rises over 16 input periods, after 4 input rises to settle
  task automatic count_core(output logic [31:0] c);
    int   e;
    logic pe, pc;
    e = 0;
    c = '0;
    pe = ext;
    pc = core;
    for (int i = 0; i < 400 && e < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if (ext && !pe) e++;
      if (core && !pc && e >= 4 && e < 20) c++;
      pe = ext;
      pc = core;
    end
    if (e < 20) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    bus_rd(OFF_PLL_CTL, d);
    chk("pll ctl", d, 32'h0001_0100);
    bus_rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    bus_wr(OFF_OP_MODE, 32'h1);
    bus_rd(OFF_OP_MODE, d);
    chk("op mode", d, 32'h1);
    count_core(d);
    chk("half rate", d, 32'h8);
    bus_rd(OFF_PERIOD, d);
    chk("period", d, 32'h8);
    // oscillator drive is the input inverted, one cycle late
    @(posedge clk_sys);
    #1;
    xq = ext;
    @(posedge clk_sys);
    #1;
    chk("crystal drive", {31'h0, xdrv}, {31'h0, !xq});
    @(posedge clk_sys);
    nmi_n <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = nmi_req;
    end
    chk("nmi request", {31'h0, seen}, 32'h1);
    @(posedge clk_sys);
    nmi_n <= 1'b1;
    bus_rd(OFF_STATUS, d);
    chk("nmi seen", {31'h0, d[NMI_SEEN_BIT]}, 32'h1);
    bus_wr(OFF_STATUS, 32'h1);
    bus_rd(OFF_STATUS, d);
    chk("nmi clear", {31'h0, d[NMI_SEEN_BIT]}, 32'h0);
    foreach (cfg[i]) begin
      bus_wr(OFF_PLL_CTL, cfg[i]);
      count_core(d);
      chk("pll rate", d, rate[i]);
    end
    @(posedge clk_sys);
    strap <= 1'b1;
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    bus_rd(OFF_PLL_CTL, d);
    chk("pll ctl strap", d, 32'h0001_0101);
    count_core(d);
    chk("strap rate", d, 32'h10);
    give_verdict();
  end
endmodule
`default_nettype wire
